// File: hdl/asrm_pkg.sv
// Constants, register map and carrier types of the audio routing matrix.
// Assumes a 32-bit Avalon-MM slave port and same-clock peripherals.
// Behaviour
// [R01] Frame-sync fields pick pins, port, generator, level sources
// [R02] Pin driven only while its enable is one
// [R03] Polarity bits invert pins 19 and 20
// [R04] Pin-output fields are six bits wide
// [R05] Pin-output source list covers all listed outputs
// [R06] Four pin registers, five fields, polarity last
// [R07] Misc lines reappear only as pin/enable sources
// [R08] Misc fields pick pins, timers, strobe, generators, levels
// [R09] Misc lines drive irq, timer, flag, inverted inputs
// [R10] Disabled pin is undriven and usable as input
// [R11] Enable fields pick levels, misc A, port, timer, flag
// [R12] Twenty enable fields, five per register
// [R13] Only flags 10 to 15 reach pins
// [R14] Constant sources make any pin general I/O
// [R15] Thirty-two channels, readable cause latches
// [R16] Priority bit steers to high or low request
// [R17] Reading a latch clears what it returned
// [R18] One source may feed any number of fields
// [R19] Frame-sync fields are five bits wide
// [R20] Enable fields reset to constant low
package asrm_pkg;
   localparam int ASRM_PINS = 20;
   localparam int ASRM_FS_W = 5;
   localparam int ASRM_PIN_W = 6;
   localparam int ASRM_MISC_W = 5;
   localparam int ASRM_PBEN_W = 6;
   localparam int ASRM_FPR = 5;
   localparam int ASRM_IRQ_N = 32;
   localparam int ASRM_AW = 8;
   // Word indices of the register map
   localparam logic [3:0] ASRM_IX_FS0 = 4'h0;
   localparam logic [3:0] ASRM_IX_PIN0 = 4'h3;
   localparam logic [3:0] ASRM_IX_MISCA = 4'h7;
   localparam logic [3:0] ASRM_IX_MISCB = 4'h8;
   localparam logic [3:0] ASRM_IX_PBEN0 = 4'h9;
   localparam logic [3:0] ASRM_IX_PRI = 4'hd;
   localparam logic [3:0] ASRM_IX_LATH = 4'he;
   localparam logic [3:0] ASRM_IX_LATL = 4'hf;
   localparam int ASRM_NCFG = 14;
   localparam int ASRM_POL19_BIT = 30;
   localparam int ASRM_POL20_BIT = 31;
   localparam logic [31:0] ASRM_CFG_RESET = 32'h0000_0000;
   // Writable bits per register; the rest read as zero
   localparam logic [31:0] ASRM_M30 = 32'h3fff_ffff;
   localparam logic [31:0] ASRM_M15 = 32'h0000_7fff;
   localparam logic [31:0] ASRM_M25 = 32'h01ff_ffff;
   localparam logic [31:0] ASRM_MALL = 32'hffff_ffff;
   // Encodings of the constant sources in each group
   localparam logic [4:0] ASRM_FS_LOW = 5'h1c;
   localparam logic [4:0] ASRM_FS_HIGH = 5'h1d;
   localparam logic [5:0] ASRM_PIN_LOW = 6'h3d;
   localparam logic [5:0] ASRM_PIN_HIGH = 6'h3e;
   localparam logic [4:0] ASRM_MISC_LOW = 5'h1c;
   localparam logic [4:0] ASRM_MISC_HIGH = 5'h1d;
   localparam logic [5:0] ASRM_PBEN_LOW = 6'h00;
   localparam logic [5:0] ASRM_PBEN_HIGH = 6'h01;

   typedef struct packed {
      logic read;
      logic write;
      logic [ASRM_AW-1:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } asrm_avm_req_t;

   // Outputs of the on-chip peripherals offered to the matrix
   typedef struct packed {
      logic [5:0] serial_port_fsync_out;
      logic [5:0] serial_port_clock_out;
      logic [11:0] serial_port_data_out;
      logic [23:0] serial_port_drive_enable;
      logic [1:0] clock_gen_clock_out;
      logic [1:0] clock_gen_fsync_out;
      logic [2:0] timer_out;
      logic [2:0] timer_drive_enable_out;
      logic [5:0] flag_line_out;
      logic [5:0] flag_drive_enable_out;
      logic parallel_strobe_out;
      logic [21:0] periph_irq_event;
   } asrm_src_t;

   // Routed inputs handed back to the peripherals
   typedef struct packed {
      logic [5:0] serial_port_fsync_in;
      logic [7:0] input_data_channel_fsync_in;
      logic [2:0] timer_in;
      logic [4:0] flag_line_in;
      logic inverted_misc_a4_in;
      logic inverted_misc_a5_in;
   } asrm_dst_t;
endpackage

// File: hdl/asrm_matrix.sv
// Routing crossbar for the audio interface: frame-sync, pin-output,
// miscellaneous and pin-enable groups, plus the interrupt latch front end.
// Assumes peripherals on mclk; pad levels are asynchronous and synchronised.
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
module asrm_matrix
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Avalon-MM slave
   input wire asrm_pkg::asrm_avm_req_t avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   // Peripheral side
   input wire asrm_pkg::asrm_src_t periph_src,
   output asrm_pkg::asrm_dst_t periph_dst,
   // Pads: level seen at the pad, drive value and drive enable
   input wire logic [19:0] pad_level,
   output logic [19:0] pin_buffer_in,
   output logic [19:0] pin_buffer_drive_enable,
   // Core interrupt requests
   output logic core_irq_high,
   output logic core_irq_low
);
   import asrm_pkg::*;

   logic [31:0] cfg [0:ASRM_NCFG-1];
   logic ack;
   logic [31:0] next_readdata;
   logic [19:0] pad_s1;
   logic [19:0] pad_s2;
   logic [19:0] pad_s3;
   logic [19:0] pin_buffer_out;
   logic [31:0] latch_h;
   logic [31:0] latch_l;
   logic [31:0] irq_prev;

   // Bus decode; a request is answered on its second cycle
   wire bus_req = avm_req.read | avm_req.write;
   wire in_map = (avm_req.address[ASRM_AW-1:6] == '0);
   wire [3:0] idx = avm_req.address[5:2];
   wire wr_fire = avm_req.write & ack & in_map;
   wire rd_fire = avm_req.read & ack & in_map;
   wire rd_cap = avm_req.read & ~ack;
   wire [31:0] be_mask = {{8{avm_req.byteenable[3]}}, {8{avm_req.byteenable[2]}},
                          {8{avm_req.byteenable[1]}}, {8{avm_req.byteenable[0]}}};
   assign avm_waitrequest = bus_req & ~ack;

   // Writable mask per configuration word
   function automatic logic [31:0] rw_mask(input int r);
      logic [31:0] m;
      m = ASRM_M30;
      if (r == 1)
      begin
         m = ASRM_M15;
      end
      else if (r == 2)
      begin
         m = ASRM_M25;
      end
      else if (r == 6)
      begin
         m = ASRM_MALL; // polarity bits live in the top two
      end
      else if (r == ASRM_NCFG-1)
      begin
         m = ASRM_MALL;
      end
      return m;
   endfunction

   // Handshake: one wait cycle, then the accepting cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack <= 1'b0;
      end
      else
      begin
         ack <= bus_req & ~ack;
      end
   end

   // Configuration words; byte lanes honoured, reserved bits kept zero
   genvar r;
   generate
      for (r = 0; r < ASRM_NCFG; r++)
      begin : g_cfg
         always_ff @(posedge mclk or negedge rstn)
         begin
            if (!rstn)
            begin
               cfg[r] <= ASRM_CFG_RESET; // [R20]
            end
            else if (wr_fire && idx == 4'(r))
            begin
               cfg[r] <= (cfg[r] & ~(be_mask & rw_mask(r)))
                         | (avm_req.writedata & be_mask & rw_mask(r));
            end
         end
      end
   endgenerate

   // Read data chosen in the wait cycle and held until the next read
   always_comb
   begin
      next_readdata = 32'h0000_0000;
      if (in_map)
      begin
         if (idx == ASRM_IX_LATH)
         begin
            next_readdata = latch_h; // [R15]
         end
         else if (idx == ASRM_IX_LATL)
         begin
            next_readdata = latch_l; // [R15]
         end
         else
         begin
            next_readdata = cfg[idx];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         avm_readdata <= 32'h0000_0000;
      end
      else if (rd_cap)
      begin
         avm_readdata <= next_readdata;
      end
   end

   // Pad synchroniser; a change counts once stages two and three agree
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pad_s1 <= 20'h0_0000;
         pad_s2 <= 20'h0_0000;
         pad_s3 <= 20'h0_0000;
         pin_buffer_out <= 20'h0_0000;
      end
      else
      begin
         pad_s1 <= pad_level;
         pad_s2 <= pad_s1;
         pad_s3 <= pad_s2;
         pin_buffer_out <= (pad_s2 & pad_s3) | (pin_buffer_out & (pad_s2 ^ pad_s3));
      end
   end

   // Source lists, one per group; the index is the field encoding.
   // Unused codes fall on zero bits so they read as a quiet low.
   wire [31:0] fs_src = {2'b00, 1'b1, 1'b0, periph_src.clock_gen_fsync_out,
                         periph_src.serial_port_fsync_out, pin_buffer_out}; // [R01]
   wire [31:0] misc_src = {2'b00, 1'b1, 1'b0, periph_src.clock_gen_fsync_out,
                           periph_src.clock_gen_clock_out, periph_src.parallel_strobe_out,
                           periph_src.timer_out, pin_buffer_out}; // [R08]
   logic [5:0] misc_a;
   logic [5:0] misc_b;
   // Flag sources are flags 10 to 15 only; the other ten never reach a pin
   wire [63:0] pin_src = {1'b0, 1'b1, 1'b0, periph_src.clock_gen_fsync_out,
                          periph_src.clock_gen_clock_out, misc_b[3:0],
                          periph_src.flag_line_out, periph_src.timer_out,
                          periph_src.serial_port_fsync_out, periph_src.serial_port_clock_out,
                          periph_src.serial_port_data_out, pin_buffer_out}; // [R05] [R13]
   wire [63:0] pben_src = {23'h00_0000, periph_src.flag_drive_enable_out,
                           periph_src.timer_drive_enable_out,
                           periph_src.serial_port_drive_enable, misc_a,
                           1'b1, 1'b0}; // [R11] [R13]

   // Frame-sync group: ports in word 0, channels 0-2 in word 1, 3-7 in word 2
   logic [13:0] fs_route;
   genvar k;
   generate
      for (k = 0; k < 14; k++)
      begin : g_fs
         localparam int W = (k < 6) ? 0 : ((k < 9) ? 1 : 2);
         localparam int F = (k < 6) ? k : ((k < 9) ? k - 6 : k - 9);
         wire [ASRM_FS_W-1:0] sel = cfg[ASRM_IX_FS0 + W][F*ASRM_FS_W +: ASRM_FS_W]; // [R19]
         assign fs_route[k] = fs_src[sel]; // [R01] [R18]
      end
   endgenerate

   // Misc group: six A lines in one word, six B lines in the next
   generate
      for (k = 0; k < 6; k++)
      begin : g_misc
         wire [ASRM_MISC_W-1:0] sel_a = cfg[ASRM_IX_MISCA][k*ASRM_MISC_W +: ASRM_MISC_W];
         wire [ASRM_MISC_W-1:0] sel_b = cfg[ASRM_IX_MISCB][k*ASRM_MISC_W +: ASRM_MISC_W];
         assign misc_a[k] = misc_src[sel_a]; // [R08] [R18]
         assign misc_b[k] = misc_src[sel_b]; // [R08] [R18]
      end
   endgenerate

   // Pin-output and pin-enable groups, five pins to a word
   logic [19:0] pin_route;
   logic [19:0] pin_en;
   generate
      for (k = 0; k < ASRM_PINS; k++)
      begin : g_pin
         wire [ASRM_PIN_W-1:0] sel_o = cfg[ASRM_IX_PIN0 + k/ASRM_FPR]
                                          [(k%ASRM_FPR)*ASRM_PIN_W +: ASRM_PIN_W]; // [R04] [R06]
         wire [ASRM_PBEN_W-1:0] sel_e = cfg[ASRM_IX_PBEN0 + k/ASRM_FPR]
                                           [(k%ASRM_FPR)*ASRM_PBEN_W +: ASRM_PBEN_W]; // [R12]
         assign pin_route[k] = pin_src[sel_o]; // [R07] [R14] [R18]
         assign pin_en[k] = pben_src[sel_e]; // [R07] [R14]
      end
   endgenerate

   // Polarity bits flip the two top pins to active low
   wire pol19 = cfg[ASRM_IX_PIN0 + 3][ASRM_POL19_BIT];
   wire pol20 = cfg[ASRM_IX_PIN0 + 3][ASRM_POL20_BIT];
   wire [19:0] pin_final = pin_route ^ {pol20, pol19, 18'h0_0000}; // [R03]

   // Pad outputs are registered, so routing to a pin costs one cycle.
   // A disabled pin shows zero drive value so nothing leaks onto the pad.
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_buffer_in <= 20'h0_0000;
         pin_buffer_drive_enable <= 20'h0_0000;
      end
      else
      begin
         pin_buffer_in <= pin_final & pin_en; // [R02] [R10]
         pin_buffer_drive_enable <= pin_en; // [R02] [R10]
      end
   end

   // Routed inputs back to the peripherals, also registered
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         periph_dst <= '0;
      end
      else
      begin
         periph_dst.serial_port_fsync_in <= fs_route[5:0]; // [R01]
         periph_dst.input_data_channel_fsync_in <= fs_route[13:6]; // [R01]
         periph_dst.timer_in <= misc_b[2:0]; // [R09]
         periph_dst.flag_line_in <= {misc_a[2], misc_a[0], misc_b[5:3]}; // [R09] [R13]
         periph_dst.inverted_misc_a4_in <= ~misc_a[4]; // [R09]
         periph_dst.inverted_misc_a5_in <= ~misc_a[5]; // [R09]
      end
   end

   // Interrupt channels: 28-31 from misc A0-A3, 22-27 from misc B0-B5
   wire [31:0] irq_chan = {misc_a[3:0], misc_b, periph_src.periph_irq_event}; // [R09] [R15]
   wire [31:0] irq_rise = irq_chan & ~irq_prev;
   wire [31:0] pri = cfg[ASRM_IX_PRI];
   wire [31:0] set_h = irq_rise & pri; // [R16]
   wire [31:0] set_l = irq_rise & ~pri; // [R16]
   // Clear only what the read returned, so a later event survives
   wire [31:0] clr_h = (rd_fire && idx == ASRM_IX_LATH) ? avm_readdata : 32'h0000_0000; // [R17]
   wire [31:0] clr_l = (rd_fire && idx == ASRM_IX_LATL) ? avm_readdata : 32'h0000_0000; // [R17]
   wire [31:0] next_latch_h = (latch_h & ~clr_h) | set_h; // set wins
   wire [31:0] next_latch_l = (latch_l & ~clr_l) | set_l; // set wins

   // Latches and the two core requests
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_prev <= 32'h0000_0000;
         latch_h <= 32'h0000_0000;
         latch_l <= 32'h0000_0000;
         core_irq_high <= 1'b0;
         core_irq_low <= 1'b0;
      end
      else
      begin
         irq_prev <= irq_chan;
         latch_h <= next_latch_h; // [R15] [R17]
         latch_l <= next_latch_l; // [R15] [R17]
         core_irq_high <= |next_latch_h; // [R16]
         core_irq_low <= |next_latch_l; // [R16]
      end
   end
endmodule

// File: testbench/asrm_matrix_assertions.sv
// Port checks of the audio routing matrix.
// Assumes one wait cycle per access and the package register map.
`timescale 1ns/1ns
module asrm_matrix_assertions
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Bus and pins
   input wire asrm_pkg::asrm_avm_req_t avm_req,
   input wire logic [31:0] avm_readdata,
   input wire logic avm_waitrequest,
   input wire logic [19:0] pin_buffer_in,
   input wire logic [19:0] pin_buffer_drive_enable
);
   import asrm_pkg::*;
   // Decode of the access seen on the bus
   wire req = avm_req.read | avm_req.write;
   wire rd_ok = avm_req.read & ~avm_waitrequest;
   wire [3:0] ix = avm_req.address[5:2];
   wire mapped = avm_req.address[7:6] == 2'h0;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_undriven_quiet;
      (pin_buffer_in & ~pin_buffer_drive_enable) == 20'h0;
   endproperty
   a_undriven_quiet: assert property (p_undriven_quiet) else $error("undriven pin value");
   property p_enable_reset;
      $rose(rstn) |-> pin_buffer_drive_enable == 20'h0;
   endproperty
   a_enable_reset: assert property (p_enable_reset) else $error("pin driven after reset");
   property p_first_wait;
      $rose(req) |-> avm_waitrequest;
   endproperty
   a_first_wait: assert property (p_first_wait) else $error("no wait cycle");
   property p_one_wait;
      req && avm_waitrequest |=> !avm_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait too long");
   property p_unmapped_zero;
      rd_ok && !mapped |-> avm_readdata == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");
   property p_pin_width;
      rd_ok && mapped && ix inside {[4'h3:4'h5]} |-> avm_readdata[31:30] == 2'h0;
   endproperty
   a_pin_width: assert property (p_pin_width) else $error("pin field width");
   property p_fs_width;
      rd_ok && mapped && ix == 4'h1 |-> avm_readdata[31:15] == 17'h0;
   endproperty
   a_fs_width: assert property (p_fs_width) else $error("frame sync width");
   property p_read_holds;
      !avm_req.read |=> $stable(avm_readdata);
   endproperty
   a_read_holds: assert property (p_read_holds) else $error("read data moved");
endmodule

bind asrm_matrix asrm_matrix_assertions i_asrm_matrix_assertions (.mclk(mclk), .rstn(rstn),
   .avm_req(avm_req), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
   .pin_buffer_in(pin_buffer_in), .pin_buffer_drive_enable(pin_buffer_drive_enable));

// File: testbench/asrm_far_end.sv
// Far side: on-chip peripheral outputs and board pads.
// Assumes the bench commands peripheral levels and board drive.
`timescale 1ns/1ns
module asrm_far_end
(
   // Clock and commands
   input wire logic mclk,
   input wire asrm_pkg::asrm_src_t src_cmd,
   input wire logic [19:0] ext_en,
   input wire logic [19:0] ext_val,
   // Matrix side
   input wire logic [19:0] pin_buffer_in,
   input wire logic [19:0] pin_buffer_drive_enable,
   output asrm_pkg::asrm_src_t periph_src,
   output logic [19:0] pad_level
);
   import asrm_pkg::*;
   logic [19:0] wander = 20'h0;
   // An unheld pad has no level, so it toggles to expose stale reads
   always @(posedge mclk)
   begin
      wander <= ~wander;
   end
   // Peripherals follow the bench; the matrix owns a pad while it drives
   assign periph_src = src_cmd;
   assign pad_level = (pin_buffer_drive_enable & pin_buffer_in) |
      (~pin_buffer_drive_enable & ((ext_en & ext_val) | (~ext_en & wander)));
endmodule

// File: testbench/asrm_matrix_tb.sv
// Self-checking bench of the audio routing matrix.
// Assumes the far-end model drives peripherals and pads.
`timescale 1ns/1ns
module asrm_matrix_tb;
   import asrm_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   asrm_avm_req_t avm_req = '0;
   asrm_src_t src = '0;
   asrm_src_t psrc;
   asrm_dst_t dst;
   logic [19:0] ext_val = 20'h0;
   logic [19:0] pad, pbi, pbe;
   logic [31:0] rdata, q;
   logic wreq, irq_h, irq_l;
   int bad_count = 0;
   int compares = 0;
   initial forever #10 mclk = ~mclk;
   asrm_far_end i_asrm_far_end (.mclk(mclk), .src_cmd(src), .ext_en(20'hfffff), .ext_val(ext_val),
      .pin_buffer_in(pbi), .pin_buffer_drive_enable(pbe), .periph_src(psrc), .pad_level(pad));
   asrm_matrix i_asrm_matrix (.mclk(mclk), .rstn(rstn), .avm_req(avm_req), .avm_readdata(rdata),
      .avm_waitrequest(wreq), .periph_src(psrc), .periph_dst(dst), .pad_level(pad),
      .pin_buffer_in(pbi), .pin_buffer_drive_enable(pbe), .core_irq_high(irq_h), .core_irq_low(irq_l));
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Held until the rising edge that samples waitrequest low; read data taken and request dropped there.
   // Right after an edge the design outputs still show their pre-edge values, so that is what is read.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avm_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wreq !== 1'b0 && n < 40);
      q = rdata;
      avm_req <= '0;
      if (n >= 40)
      begin
         bad_count++;
         $display("MISMATCH %0t bus timeout", $time);
         test_done;
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
      bus(1'b0, a, 32'h0);
      chk(q, e, m);
   endtask
   task automatic drive(input logic [92:0] s, input logic [19:0] p);
      @(posedge mclk);
      src <= s;
      ext_val <= p;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic t_reset;
      tick(1);
      chk({12'h0, pbe}, 32'h0, "enables at reset");
      rdchk(8'h24, 32'h0, "enable route at reset");
      $display("reset test done");
   endtask
   task automatic t_regs;
      logic [7:0] ad[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h24, 8'h34};
      logic [31:0] ex[7] = '{32'h3fffffff, 32'h7fff, 32'h1ffffff, 32'h3fffffff, '1, 32'h3fffffff, '1};
      for (int i = 0; i < 7; i++)
      begin
         bus(1'b1, ad[i], 32'hffffffff);
         rdchk(ad[i], ex[i], "field widths");
         bus(1'b1, ad[i], 32'h0);
      end
      bus(1'b1, 8'h40, 32'hffffffff);
      rdchk(8'h40, 32'h0, "unmapped");
      $display("register test done");
   endtask
   task automatic t_gpio;
      bus(1'b1, 8'h0c, {26'h0, ASRM_PIN_HIGH});
      bus(1'b1, 8'h1c, {27'h0, ASRM_MISC_HIGH});
      bus(1'b1, 8'h24, 32'h2);
      tick(2);
      chk({30'h0, pbe[0], pbi[0]}, 32'h3, "gated pin drives");
      bus(1'b1, 8'h24, {26'h0, ASRM_PBEN_LOW});
      tick(2);
      chk({30'h0, pbe[0], pbi[0]}, 32'h0, "disabled pin");
      bus(1'b1, 8'h30, {2'h0, ASRM_PBEN_HIGH, ASRM_PBEN_HIGH, 18'h0});
      bus(1'b1, 8'h18, {2'h1, ASRM_PIN_HIGH, ASRM_PIN_HIGH, 18'h0});
      tick(2);
      chk({30'h0, pbi[19:18]}, 32'h2, "pin19 inverted");
      bus(1'b1, 8'h18, {2'h2, ASRM_PIN_HIGH, ASRM_PIN_HIGH, 18'h0});
      tick(2);
      chk({30'h0, pbi[19:18]}, 32'h1, "pin20 inverted");
      $display("gpio test done");
   endtask
   task automatic t_pinsrc;
      logic [5:0] pc[10] = '{6'h14, 6'h1f, 6'h20, 6'h26, 6'h2c, 6'h2e, 6'h2f, 6'h34, 6'h39, 6'h3b};
      int pb[10] = '{69, 80, 81, 87, 38, 40, 29, 34, 43, 41};
      bus(1'b1, 8'h24, {14'h0, ASRM_PBEN_HIGH, 12'h0});
      for (int i = 0; i < 10; i++)
      begin
         bus(1'b1, 8'h0c, {14'h0, pc[i], 12'h0});
         drive(93'h1 << pb[i], 20'h0);
         tick(2);
         chk({31'h0, pbi[2]}, 32'h1, "source high");
         drive(93'h0, 20'h0);
         tick(2);
         chk({31'h0, pbi[2]}, 32'h0, "source low");
      end
      // Pin 3 enable taken from the first flag enable line, then back to constant high
      bus(1'b1, 8'h24, {14'h0, 6'h23, 12'h0});
      drive(93'h1 << 23, 20'h0);
      tick(2);
      chk({31'h0, pbe[2]}, 32'h1, "flag enable routed");
      bus(1'b1, 8'h24, {14'h0, ASRM_PBEN_HIGH, 12'h0});
      $display("pin source test done");
   endtask
   task automatic t_fsync;
      bus(1'b1, 8'h00, {2'h0, {6{5'h01}}});
      bus(1'b1, 8'h04, {17'h0, 5'h00, ASRM_FS_LOW, ASRM_FS_HIGH});
      drive(93'h0, 20'h2);
      tick(6);
      chk({26'h0, dst.serial_port_fsync_in}, 32'h3f, "pad fan-out");
      chk({29'h0, dst.input_data_channel_fsync_in[2:0]}, 32'h1, "levels");
      drive(93'h0, 20'h0);
      tick(6);
      chk({26'h0, dst.serial_port_fsync_in}, 32'h0, "pad low");
      bus(1'b1, 8'h08, {7'h0, {5{5'h14}}});
      drive(93'h1 << 87, 20'h0);
      tick(2);
      chk({27'h0, dst.input_data_channel_fsync_in[7:3]}, 32'h1f, "port fsync");
      $display("frame sync test done");
   endtask
   task automatic t_misc;
      // B0 and B3 follow timer 0; A2 and A4 are held high
      bus(1'b1, 8'h20, {12'h0, 5'h14, 10'h0, 5'h14});
      bus(1'b1, 8'h1c, {2'h0, 5'h00, ASRM_MISC_HIGH, 5'h00, ASRM_MISC_HIGH, 10'h0});
      bus(1'b1, 8'h0c, {14'h0, 6'h35, 12'h0});
      drive(93'h1 << 38, 20'h0);
      tick(6);
      chk({29'h0, dst.timer_in}, 32'h1, "timer via misc");
      chk({30'h0, dst.inverted_misc_a4_in, dst.inverted_misc_a5_in}, 32'h1, "inverted");
      chk({27'h0, dst.flag_line_in}, 32'h11, "flags via misc");
      chk({31'h0, pbi[2]}, 32'h1, "misc to pin");
      $display("misc test done");
   endtask
   task automatic t_irq;
      bus(1'b0, 8'h38, 32'h0);
      bus(1'b0, 8'h3c, 32'h0);
      bus(1'b1, 8'h34, 32'h1);
      drive(93'h1, 20'h0);
      tick(2);
      chk({30'h0, irq_h, irq_l}, 32'h2, "high request");
      drive(93'h3, 20'h0);
      tick(2);
      chk({30'h0, irq_h, irq_l}, 32'h3, "both requests");
      rdchk(8'h38, 32'h1, "high cause");
      rdchk(8'h3c, 32'h2, "low cause");
      tick(1);
      chk({30'h0, irq_h, irq_l}, 32'h0, "after reads");
      rdchk(8'h38, 32'h0, "cleared");
      // Timer 0 rising lifts misc B0 and B3, so channels 22 and 25 latch low
      drive(93'h1 << 38, 20'h0);
      tick(2);
      rdchk(8'h3c, 32'h0240_0000, "misc channels");
      $display("interrupt test done");
   endtask
   initial
   begin
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_regs;
      t_gpio;
      t_pinsrc;
      t_fsync;
      t_misc;
      t_irq;
      test_done;
   end
endmodule
